// *** inc/surface_port_pkg.sv ***
package surface_port_pkg;

	////////////////////////////////////////////////////////////////////////////////
	// register map, byte addresses on the slave port
	localparam logic [8:0]  REG_COMMAND    = 9'h000;
	localparam logic [8:0]  REG_STATUS     = 9'h004;
	localparam logic [8:0]  REG_ADDR_U     = 9'h008;
	localparam logic [8:0]  REG_ADDR_V     = 9'h00C;
	localparam logic [8:0]  REG_ADDR_R     = 9'h010;
	localparam logic [8:0]  REG_MIP_LEVEL  = 9'h014;
	localparam logic [8:0]  REG_SURF_CFG   = 9'h018;
	localparam logic [8:0]  REG_SURF_SIZE  = 9'h01C;
	localparam logic [8:0]  REG_SURF_LIMIT = 9'h020;
	localparam logic [8:0]  REG_SURF_PITCH = 9'h024;
	localparam logic [8:0]  REG_SURF_BASE  = 9'h028;
	localparam logic [8:0]  REG_LANE_MASKS = 9'h02C;
	localparam logic [8:0]  REG_SLOT       = 9'h030;
	localparam logic [8:0]  REG_SRC0_LO    = 9'h034;
	localparam logic [8:0]  REG_SRC0_HI    = 9'h038;
	localparam logic [8:0]  REG_SRC1_LO    = 9'h03C;
	localparam logic [8:0]  REG_SRC1_HI    = 9'h040;
	localparam logic [8:0]  REG_WDATA0     = 9'h050;
	localparam logic [8:0]  REG_RDATA0     = 9'h060;
	localparam int          MEM_WINDOW_BIT = 8;

	////////////////////////////////////////////////////////////////////////////////
	// surface store and reset values
	localparam int          MEM_WORDS      = 64;
	localparam int          MEM_AW         = 6;
	localparam int          CHANNELS       = 4;
	localparam logic [31:0] RESET_WORD     = 32'h0000_0000;
	localparam logic [31:0] DESC_WMASK     = 32'h0000_3F37;
	localparam logic [31:0] CFG_WMASK      = 32'h0000_007F;
	localparam logic [31:0] SIZE_WMASK     = 32'h00FF_FFFF;
	localparam logic [31:0] SLOT_WMASK     = 32'h0000_000F;

	////////////////////////////////////////////////////////////////////////////////
	// atomic operation codes, descriptor bits 11:8
	localparam logic [3:0]  atomic_compare_write_qword = 4'h0;
	localparam logic [3:0]  atomic_and                 = 4'h1;
	localparam logic [3:0]  atomic_or                  = 4'h2;
	localparam logic [3:0]  atomic_xor                 = 4'h3;
	localparam logic [3:0]  atomic_move                = 4'h4;
	localparam logic [3:0]  atomic_increment           = 4'h5;
	localparam logic [3:0]  atomic_decrement           = 4'h6;
	localparam logic [3:0]  atomic_add                 = 4'h7;
	localparam logic [3:0]  atomic_subtract            = 4'h8;
	localparam logic [3:0]  atomic_reverse_subtract    = 4'h9;
	localparam logic [3:0]  atomic_signed_max          = 4'hA;
	localparam logic [3:0]  atomic_signed_min          = 4'hB;
	localparam logic [3:0]  atomic_unsigned_max        = 4'hC;
	localparam logic [3:0]  atomic_unsigned_min        = 4'hD;
	localparam logic [3:0]  atomic_compare_write       = 4'hE;
	localparam logic [3:0]  atomic_pre_decrement       = 4'hF;

	////////////////////////////////////////////////////////////////////////////////
	// enumerations
	typedef enum logic [2:0] {
		msg_typed_read,
		msg_typed_write,
		msg_typed_atomic,
		msg_untyped_read,
		msg_untyped_write,
		msg_untyped_atomic
	} msg_kind_t;

	typedef enum logic [1:0] {
		sixteen_lane_mode,
		eight_lane_mode,
		four_by_two_mode
	} lane_mode_t;

	typedef enum logic [2:0] {
		one_dim_surface,
		two_dim_surface,
		three_dim_surface,
		linear_buffer_surface,
		structured_buffer_surface
	} surface_type_t;

	typedef enum logic [1:0] {
		single_channel_unsigned_format,
		single_channel_signed_format,
		single_channel_float_format,
		byte_unsigned_format
	} surf_format_t;

	////////////////////////////////////////////////////////////////////////////////
	// register layouts
	typedef struct packed {
		logic [17:0] rsvd_hi;
		logic        bit13;
		logic        bit12;
		logic [3:0]  op_or_chmask;
		logic [1:0]  rsvd_mid;
		lane_mode_t  mode;
		logic        rsvd_lo;
		msg_kind_t   kind;
	} desc_t;

	typedef struct packed {
		logic [24:0]   rsvd;
		logic          header_present;
		surf_format_t  fmt;
		logic          arrayed;
		surface_type_t stype;
	} surf_cfg_t;

	typedef struct packed {
		logic [7:0] rsvd;
		logic [7:0] depth;
		logic [7:0] height;
		logic [7:0] width;
	} surf_size_t;

	// atomic unit carriers
	typedef struct packed {
		logic [3:0]  op;
		logic        qword;
		logic [63:0] old_val;
		logic [63:0] src0;
		logic [63:0] src1;
	} alu_req_t;

	typedef struct packed {
		logic [63:0] new_val;
		logic [63:0] ret_val;
		logic        write_en;
	} alu_res_t;

endpackage

// *** rtl/surface_atomic_alu.sv ***
`timescale 1ns/100ps
`default_nettype none
module surface_atomic_alu
	import surface_port_pkg::*;
(
	// operation in
	input  wire alu_req_t i_req,
	// result out
	output alu_res_t      o_res
);

	logic [31:0] old_lo;
	logic [31:0] s0;
	logic [31:0] s1;

	always_comb
	begin
		old_lo = i_req.old_val[31:0];
		s0 = i_req.src0[31:0];
		s1 = i_req.src1[31:0];
		o_res.new_val = {32'h0000_0000, old_lo};
		o_res.ret_val = {32'h0000_0000, old_lo};
		o_res.write_en = 1'b1;
		// sums wrap silently in 32 bits
		case (i_req.op)
			atomic_and:              o_res.new_val[31:0] = old_lo & s0;
			atomic_or:               o_res.new_val[31:0] = old_lo | s0;
			atomic_xor:              o_res.new_val[31:0] = old_lo ^ s0;
			atomic_move:             o_res.new_val[31:0] = s0;
			atomic_increment:        o_res.new_val[31:0] = old_lo + 32'h0000_0001;
			atomic_decrement:        o_res.new_val[31:0] = old_lo - 32'h0000_0001;
			atomic_add:              o_res.new_val[31:0] = old_lo + s0;
			atomic_subtract:         o_res.new_val[31:0] = old_lo - s0;
			atomic_reverse_subtract: o_res.new_val[31:0] = s0 - old_lo;
			atomic_signed_max:
				o_res.new_val[31:0] = ($signed(old_lo) > $signed(s0)) ? old_lo : s0;
			atomic_signed_min:
				o_res.new_val[31:0] = ($signed(old_lo) < $signed(s0)) ? old_lo : s0;
			atomic_unsigned_max:     o_res.new_val[31:0] = (old_lo > s0) ? old_lo : s0;
			atomic_unsigned_min:     o_res.new_val[31:0] = (old_lo < s0) ? old_lo : s0;
			atomic_compare_write:    o_res.new_val[31:0] = (s0 == old_lo) ? s1 : old_lo;
			atomic_pre_decrement:
			begin
				o_res.new_val[31:0] = old_lo - 32'h0000_0001;
				o_res.ret_val[31:0] = old_lo - 32'h0000_0001;
			end
			default:
			begin
				// code zero is the qword compare-write, reserved on typed surfaces
				if (i_req.qword)
				begin
					o_res.new_val = (i_req.src0 == i_req.old_val) ? i_req.src1 : i_req.old_val;
					o_res.ret_val = i_req.old_val;
				end
				else
				begin
					o_res.write_en = 1'b0;
				end
			end
		endcase
	end

endmodule
`default_nettype wire

// *** rtl/surface_rw_atomic_port.sv ***
`timescale 1ns/100ps
`default_nettype none
// Overview of operation
// - raw buffer addresses by U alone as byte offset; sender keeps it dword aligned.
// - structured buffer: U is element index, V dword-aligned byte offset inside.
// - untyped accesses touch up to four dwords, red lowest, then green, blue, alpha.
// - atomics touch only the first dword at the addressed location, the first two for qword compare-write.
// - atomic read and write happen as one step, nothing intervenes.
// - new value per opcode; all return old value except pre-decrement returns new.
// - compare-write stores src1 when src0 equals old, returns old.
// - qword compare-write compares, stores and returns full 8-byte values.
// - signed max/min compare signed, everything else but the qword compare-write is 32-bit unsigned.
// - add and subtract wrap with no overflow indication.
// - typed reads and writes convert data only in byte format, typed atomics never; unsigned, signed and float keep their bits.
// - untyped accesses move data unchanged.
// - sixteen-lane: execution mask AND header mask, or execution mask without header.
// - eight-lane: low execution bits AND header half; typed picks half, untyped low.
// - four-by-two: OR each nibble of low execution bits into two enables.
// - out-of-bounds reads return zero in every channel.
// - out-of-bounds writes are dropped; overlapping write order undefined.
// - coordinates interpreted per surface type and array setting; unused ones ignored.
// - atomic opcode sits in descriptor bits 11:8 with the listed codes.
// - atomic return data only when descriptor bit 13 is set.
// - lane-half select zero picks low header bits, one picks high.
module surface_rw_atomic_port
	import surface_port_pkg::*;
(
	// clock and reset
	input  wire logic        i_ref_clk,
	input  wire logic        i_reset,
	// avalon-mm slave
	input  wire logic [8:0]  i_address,
	input  wire logic        i_read,
	input  wire logic        i_write,
	input  wire logic [31:0] i_writedata,
	input  wire logic [3:0]  i_byteenable,
	output logic      [31:0] o_readdata,
	output logic             o_waitrequest,
	// engine status
	output logic             o_busy
);

	typedef struct packed {
		logic                         wait_q;
		logic [31:0]                  rdata;
		desc_t                        desc;
		surf_cfg_t                    cfg;
		surf_size_t                   size;
		logic [31:0]                  limit;
		logic [31:0]                  pitch;
		logic [31:0]                  base;
		logic [31:0]                  u;
		logic [31:0]                  v;
		logic [31:0]                  r;
		logic [31:0]                  mip_level;
		logic [31:0]                  masks;
		logic [3:0]                   slot;
		logic [63:0]                  src0;
		logic [63:0]                  src1;
		logic [CHANNELS-1:0][31:0]    wdata;
		logic [CHANNELS-1:0][31:0]    rdata_ch;
		logic                         busy;
		logic                         oob;
		logic                         ret_valid;
		logic                         skipped;
		logic                         bad_op;
		logic [MEM_WORDS-1:0][31:0]   mem;
	} state_t;

	state_t   s_q;
	state_t   s_d;
	alu_req_t alu_req;
	alu_res_t alu_res;

	////////////////////////////////////////////////////////////////////////////////
	// helpers

	function automatic logic [31:0] be_merge(input logic [31:0] old, input logic [31:0] nw,
		input logic [3:0] be);
		logic [31:0] res;
		res = old;
		for (int b = 0; b < 4; b++)
		begin
			if (be[b])
				res[b*8 +: 8] = nw[b*8 +: 8];
		end
		return res;
	endfunction

	// store side of the typed conversion; 32-bit formats keep their bits
	function automatic logic [31:0] fmt_store(input surf_format_t f, input logic [31:0] d);
		if (f == byte_unsigned_format)
			return (d > 32'h0000_00FF) ? 32'h0000_00FF : d;
		return d;
	endfunction

	function automatic logic [31:0] fmt_load(input surf_format_t f, input logic [31:0] d);
		if (f == byte_unsigned_format)
			return {24'h00_0000, d[7:0]};
		return d;
	endfunction

	function automatic logic [15:0] active_mask(input lane_mode_t m, input logic [31:0] masks,
		input logic hdr, input logic typed, input logic half);
		logic [15:0] ex;
		logic [15:0] hm;
		logic [7:0]  hsel;
		ex = masks[15:0];
		hm = masks[31:16];
		hsel = (typed && half) ? hm[15:8] : hm[7:0];
		case (m)
			sixteen_lane_mode: return hdr ? (ex & hm) : ex;
			eight_lane_mode:   return {8'h00, ex[7:0] & (hdr ? hsel : 8'hFF)};
			four_by_two_mode:  return {14'h0, |ex[7:4], |ex[3:0]};
			default:           return 16'h0000;
		endcase
	endfunction

	function automatic logic in_mem(input logic [31:0] w);
		return w < 32'(MEM_WORDS);
	endfunction

	////////////////////////////////////////////////////////////////////////////////
	// atomic unit

	surface_atomic_alu u_alu
	(
		.i_req (alu_req),
		.o_res (alu_res)
	);

	////////////////////////////////////////////////////////////////////////////////
	// next state

	logic [15:0] lanes;
	logic        typed;
	logic        half_sel;
	logic [31:0] ubyte;
	logic [31:0] uword;
	logic [31:0] cx;
	logic [31:0] cy;
	logic [31:0] cz;
	logic        t_inb;
	logic [31:0] texel;
	logic [31:0] w0;
	logic [31:0] w1;
	logic        a_inb;
	logic        qword;
	logic [CHANNELS-1:0] ch_inb;
	logic [CHANNELS-1:0][31:0] ch_word;
	logic [8:0]  off;

	always_comb
	begin
		s_d = s_q;
		s_d.wait_q = 1'b1;
		off = i_address;
		typed = (s_q.desc.kind == msg_typed_read) || (s_q.desc.kind == msg_typed_write)
			|| (s_q.desc.kind == msg_typed_atomic);
		// typed atomics carry the lane half in bit 12, typed read/write in bit 13
		half_sel = (s_q.desc.kind == msg_typed_atomic) ? s_q.desc.bit12 : s_q.desc.bit13;
		lanes = active_mask(s_q.desc.mode, s_q.masks, s_q.cfg.header_present, typed, half_sel);

		// untyped addressing
		if (s_q.cfg.stype == structured_buffer_surface)
			ubyte = 32'(s_q.u * s_q.pitch) + s_q.v;
		else
			ubyte = s_q.u;
		uword = s_q.base + {2'b00, ubyte[31:2]};
		for (int c = 0; c < CHANNELS; c++)
		begin
			ch_word[c] = uword + 32'(c);
			ch_inb[c] = ({2'b00, ubyte} + 34'(4 * c + 4) <= {2'b00, s_q.limit})
				&& in_mem(uword + 32'(c));
		end

		// typed coordinates; unused parameters are ignored
		cx = s_q.u;
		cy = 32'h0000_0000;
		cz = 32'h0000_0000;
		case (s_q.cfg.stype)
			one_dim_surface:
				if (s_q.cfg.arrayed)
					cz = (s_q.desc.mode == four_by_two_mode) ? s_q.r : s_q.v;
			two_dim_surface:
			begin
				cy = s_q.v;
				if (s_q.cfg.arrayed)
					cz = s_q.r;
			end
			three_dim_surface:
			begin
				cy = s_q.v;
				cz = s_q.r;
			end
			default:
			begin
			end
		endcase
		texel = s_q.base + cx + 32'(s_q.size.width * (cy + 32'(s_q.size.height * cz)));
		t_inb = (cx < {24'h00_0000, s_q.size.width}) && in_mem(texel);
		if ((s_q.cfg.stype == two_dim_surface) || (s_q.cfg.stype == three_dim_surface))
			t_inb = t_inb && (cy < {24'h00_0000, s_q.size.height});
		if ((s_q.cfg.stype == three_dim_surface) || s_q.cfg.arrayed)
			t_inb = t_inb && (cz < {24'h00_0000, s_q.size.depth});

		// atomic addressing: first dword only, second one for the qword form
		qword = !typed && (s_q.desc.op_or_chmask == atomic_compare_write_qword);
		w0 = typed ? texel : uword;
		w1 = w0 + 32'h0000_0001;
		a_inb = typed ? t_inb : (ch_inb[0] && (!qword || ch_inb[1]));
		alu_req.op = s_q.desc.op_or_chmask;
		alu_req.qword = qword;
		alu_req.old_val = {(qword && a_inb) ? s_q.mem[MEM_AW'(w1)] : 32'h0000_0000,
			a_inb ? s_q.mem[MEM_AW'(w0)] : 32'h0000_0000};
		alu_req.src0 = s_q.src0;
		alu_req.src1 = s_q.src1;

		////////////////////////////////////////////////////////////////////////////////
		// engine: a whole message in one cycle, so nothing can slip in between
		if (s_q.busy)
		begin
			s_d.busy = 1'b0;
			if (!lanes[s_q.slot])
				s_d.skipped = 1'b1;
			else
			begin
				case (s_q.desc.kind)
					msg_typed_read:
					begin
						s_d.rdata_ch = '0;
						if (t_inb)
							s_d.rdata_ch[0] = fmt_load(s_q.cfg.fmt, s_q.mem[MEM_AW'(texel)]);
						else
							s_d.oob = 1'b1;
					end
					msg_typed_write:
					begin
						if (t_inb)
							s_d.mem[MEM_AW'(texel)] = fmt_store(s_q.cfg.fmt, s_q.wdata[0]);
						else
							s_d.oob = 1'b1;
					end
					msg_untyped_read:
					begin
						s_d.rdata_ch = '0;
						for (int c = 0; c < CHANNELS; c++)
						begin
							if (!s_q.desc.op_or_chmask[c])
							begin
								if (ch_inb[c])
									s_d.rdata_ch[c] = s_q.mem[MEM_AW'(ch_word[c])];
								else
									s_d.oob = 1'b1;
							end
						end
					end
					msg_untyped_write:
					begin
						for (int c = 0; c < CHANNELS; c++)
						begin
							if (!s_q.desc.op_or_chmask[c])
							begin
								if (ch_inb[c])
									s_d.mem[MEM_AW'(ch_word[c])] = s_q.wdata[c];
								else
									s_d.oob = 1'b1;
							end
						end
					end
					msg_typed_atomic, msg_untyped_atomic:
					begin
						if (!alu_res.write_en)
							s_d.bad_op = 1'b1;
						else
						begin
							if (a_inb)
							begin
								s_d.mem[MEM_AW'(w0)] = alu_res.new_val[31:0];
								if (qword)
									s_d.mem[MEM_AW'(w1)] = alu_res.new_val[63:32];
							end
							else
								s_d.oob = 1'b1;
							if (s_q.desc.bit13)
							begin
								s_d.rdata_ch = '0;
								s_d.ret_valid = 1'b1;
								if (a_inb)
								begin
									s_d.rdata_ch[0] = alu_res.ret_val[31:0];
									s_d.rdata_ch[1] = qword ? alu_res.ret_val[63:32] : 32'h0000_0000;
								end
							end
						end
					end
					default:
						s_d.bad_op = 1'b1;
				endcase
			end
		end

		////////////////////////////////////////////////////////////////////////////////
		// bus slave: one wait cycle, then a single-cycle acknowledge
		// accesses are held off while a message runs, so the bus never races the engine
		if ((i_read || i_write) && s_q.wait_q && !s_q.busy)
		begin
			s_d.wait_q = 1'b0;
			s_d.rdata = 32'h0000_0000;
			if (off[MEM_WINDOW_BIT])
			begin
				if (i_write)
					s_d.mem[off[7:2]] = be_merge(s_q.mem[off[7:2]], i_writedata, i_byteenable);
				else
					s_d.rdata = s_q.mem[off[7:2]];
			end
			else if (off == REG_COMMAND)
			begin
				if (i_write)
				begin
					s_d.desc = desc_t'(be_merge(s_q.desc, i_writedata, i_byteenable) & DESC_WMASK);
					s_d.busy = 1'b1;
					s_d.oob = 1'b0;
					s_d.ret_valid = 1'b0;
					s_d.skipped = 1'b0;
					s_d.bad_op = 1'b0;
				end
				else
					s_d.rdata = s_q.desc;
			end
			else if (off == REG_STATUS)
			begin
				if (i_read)
					s_d.rdata = {lanes, 11'h000, s_q.bad_op, s_q.skipped, s_q.ret_valid, s_q.oob,
						s_q.busy};
			end
			else if (off == REG_ADDR_U)
			begin
				if (i_write) s_d.u = be_merge(s_q.u, i_writedata, i_byteenable);
				else s_d.rdata = s_q.u;
			end
			else if (off == REG_ADDR_V)
			begin
				if (i_write) s_d.v = be_merge(s_q.v, i_writedata, i_byteenable);
				else s_d.rdata = s_q.v;
			end
			else if (off == REG_ADDR_R)
			begin
				if (i_write) s_d.r = be_merge(s_q.r, i_writedata, i_byteenable);
				else s_d.rdata = s_q.r;
			end
			else if (off == REG_MIP_LEVEL)
			begin
				// stored only: the store holds a single level
				if (i_write) s_d.mip_level = be_merge(s_q.mip_level, i_writedata, i_byteenable);
				else s_d.rdata = s_q.mip_level;
			end
			else if (off == REG_SURF_CFG)
			begin
				if (i_write)
					s_d.cfg = surf_cfg_t'(be_merge(s_q.cfg, i_writedata, i_byteenable) & CFG_WMASK);
				else
					s_d.rdata = s_q.cfg;
			end
			else if (off == REG_SURF_SIZE)
			begin
				if (i_write)
					s_d.size = surf_size_t'(be_merge(s_q.size, i_writedata, i_byteenable) & SIZE_WMASK);
				else
					s_d.rdata = s_q.size;
			end
			else if (off == REG_SURF_LIMIT)
			begin
				if (i_write) s_d.limit = be_merge(s_q.limit, i_writedata, i_byteenable);
				else s_d.rdata = s_q.limit;
			end
			else if (off == REG_SURF_PITCH)
			begin
				if (i_write) s_d.pitch = be_merge(s_q.pitch, i_writedata, i_byteenable);
				else s_d.rdata = s_q.pitch;
			end
			else if (off == REG_SURF_BASE)
			begin
				if (i_write) s_d.base = be_merge(s_q.base, i_writedata, i_byteenable);
				else s_d.rdata = s_q.base;
			end
			else if (off == REG_LANE_MASKS)
			begin
				if (i_write) s_d.masks = be_merge(s_q.masks, i_writedata, i_byteenable);
				else s_d.rdata = s_q.masks;
			end
			else if (off == REG_SLOT)
			begin
				if (i_write)
					s_d.slot = 4'(be_merge({28'h000_0000, s_q.slot}, i_writedata, i_byteenable)
						& SLOT_WMASK);
				else
					s_d.rdata = {28'h000_0000, s_q.slot};
			end
			else if (off == REG_SRC0_LO)
			begin
				if (i_write) s_d.src0[31:0] = be_merge(s_q.src0[31:0], i_writedata, i_byteenable);
				else s_d.rdata = s_q.src0[31:0];
			end
			else if (off == REG_SRC0_HI)
			begin
				if (i_write) s_d.src0[63:32] = be_merge(s_q.src0[63:32], i_writedata, i_byteenable);
				else s_d.rdata = s_q.src0[63:32];
			end
			else if (off == REG_SRC1_LO)
			begin
				if (i_write) s_d.src1[31:0] = be_merge(s_q.src1[31:0], i_writedata, i_byteenable);
				else s_d.rdata = s_q.src1[31:0];
			end
			else if (off == REG_SRC1_HI)
			begin
				if (i_write) s_d.src1[63:32] = be_merge(s_q.src1[63:32], i_writedata, i_byteenable);
				else s_d.rdata = s_q.src1[63:32];
			end
			else if (off[8:4] == REG_WDATA0[8:4])
			begin
				if (i_write)
					s_d.wdata[off[3:2]] = be_merge(s_q.wdata[off[3:2]], i_writedata, i_byteenable);
				else
					s_d.rdata = s_q.wdata[off[3:2]];
			end
			else if (off[8:4] == REG_RDATA0[8:4])
			begin
				if (i_read)
					s_d.rdata = s_q.rdata_ch[off[3:2]];
			end
		end
	end

	always_ff @(posedge i_ref_clk or posedge i_reset)
	begin
		if (i_reset)
		begin
			s_q <= '0;
			s_q.wait_q <= 1'b1;
		end
		else
			s_q <= s_d;
	end

	assign o_readdata = s_q.rdata;
	assign o_waitrequest = s_q.wait_q;
	assign o_busy = s_q.busy;

endmodule
`default_nettype wire

// *** tb/surface_port_assertions.sv ***
`timescale 1ns/100ps
`default_nettype none
module surface_port_assertions
	import surface_port_pkg::*;
(
	// clock and reset
	input  wire logic        i_ref_clk,
	input  wire logic        i_reset,
	// bus
	input  wire logic [8:0]  i_address,
	input  wire logic        i_read,
	input  wire logic        i_write,
	input  wire logic [31:0] i_writedata,
	input  wire logic [3:0]  i_byteenable,
	input  wire logic [31:0] o_readdata,
	input  wire logic        o_waitrequest,
	input  wire logic        o_busy
);
	default clocking @(posedge i_ref_clk); endclocking
	default disable iff (i_reset);
	wire logic rd_ack = i_read && !o_waitrequest;
	wire logic cmd_wr = i_write && o_waitrequest && i_address == REG_COMMAND;
	////////////////////////////////////////////////////////////////////////////////
	a_ack_single: assert property (!o_waitrequest |=> o_waitrequest)
		else $error("acknowledge wider than one cycle");
	a_idle_quiet: assert property (!(i_read || i_write) |=> o_waitrequest)
		else $error("acknowledge without request");
	a_ack_bound: assert property ((i_read || i_write) && o_waitrequest |-> ##[1:3] !o_waitrequest)
		else $error("request not answered");
	a_busy_one: assert property (o_busy |=> !o_busy)
		else $error("engine busy too long");
	a_busy_stall: assert property (o_busy |=> o_waitrequest)
		else $error("access accepted while engine busy");
	a_busy_cause: assert property ($rose(o_busy) |-> $past(cmd_wr))
		else $error("engine started without command");
	a_status_idle: assert property (rd_ack && i_address == REG_STATUS |-> !o_readdata[0])
		else $error("status shows busy to the bus");
	a_unmapped_zero: assert property (rd_ack && i_address == 9'h044 |-> o_readdata == 32'h0000_0000)
		else $error("unmapped read not zero");
	c_read: cover property (rd_ack);
	c_write: cover property (i_write && !o_waitrequest);
	c_busy: cover property (o_busy);
endmodule
bind surface_rw_atomic_port surface_port_assertions surface_port_assertions_inst (
	.i_ref_clk(i_ref_clk), .i_reset(i_reset), .i_address(i_address), .i_read(i_read),
	.i_write(i_write), .i_writedata(i_writedata), .i_byteenable(i_byteenable),
	.o_readdata(o_readdata), .o_waitrequest(o_waitrequest), .o_busy(o_busy));
`default_nettype wire

// *** tb/tb_top.sv ***
`timescale 1ns/100ps
`default_nettype none
module tb_top
	import surface_port_pkg::*;
;
	logic        ref_clk = 1'b0;
	logic        reset = 1'b1;
	logic [8:0]  address;
	logic        read;
	logic        write;
	logic [31:0] writedata;
	logic [3:0]  byteenable;
	logic [31:0] readdata;
	logic        waitrequest;
	logic        busy;
	logic [31:0] exp_q[$];
	logic [31:0] old, s0, s1, nw;
	logic [31:0] w[4];
	logic [4:0]  op;
	int          err_total = 0;
	int          n_checks = 0;
	surface_rw_atomic_port surface_rw_atomic_port_inst (.i_ref_clk(ref_clk), .i_reset(reset),
		.i_address(address), .i_read(read), .i_write(write), .i_writedata(writedata),
		.i_byteenable(byteenable), .o_readdata(readdata), .o_waitrequest(waitrequest),
		.o_busy(busy));
	thread_master thread_master_inst (.i_ref_clk(ref_clk), .i_waitrequest(waitrequest),
		.o_address(address), .o_read(read), .o_write(write), .o_writedata(writedata),
		.o_byteenable(byteenable));
	////////////////////////////////////////////////////////////////////////////////
	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		n_checks++;
		if (seen !== exp)
		begin
			err_total++;
			$display("ERROR %0t read %h expected %h", $time, seen, exp);
		end
	endtask
	task automatic end_sim();
		if (err_total == 0 && n_checks > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask
	task automatic wr(input logic [8:0] a, input logic [31:0] d);
		thread_master_inst.access(1'b1, a, d);
	endtask
	task automatic rd(input logic [8:0] a, input logic [31:0] e);
		exp_q.push_back(e);
		thread_master_inst.access(1'b0, a, 32'h0000_0000);
	endtask
	function automatic logic [31:0] aop(input logic [3:0] c, input logic [31:0] o,
		input logic [31:0] a, input logic [31:0] b);
		case (c)
			4'h1: return o & a;
			4'h2: return o | a;
			4'h3: return o ^ a;
			4'h4: return a;
			4'h5: return o + 32'h0000_0001;
			4'h7: return o + a;
			4'h8: return o - a;
			4'h9: return a - o;
			4'hA: return ($signed(o) > $signed(a)) ? o : a;
			4'hB: return ($signed(o) < $signed(a)) ? o : a;
			4'hC: return (o > a) ? o : a;
			4'hD: return (o < a) ? o : a;
			4'hE: return (a == o) ? b : o;
			default: return o - 32'h0000_0001;
		endcase
	endfunction
	////////////////////////////////////////////////////////////////////////////////
	initial
		forever #25 ref_clk = ~ref_clk;
	always @(posedge ref_clk)
		if (read && !waitrequest)
			if (exp_q.size() > 0)
				check(readdata, exp_q.pop_front());
			else
				check(32'h0000_0000, 32'h0000_0001);
	initial
	begin
		#100us;
		err_total++;
		end_sim();
	end
	initial
	begin
		void'($urandom(3));
		repeat (5) @(posedge ref_clk);
		reset <= 1'b0;
		wr(REG_SURF_CFG, 32'h0000_0003);
		wr(REG_SURF_LIMIT, 32'h0000_0100);
		wr(REG_LANE_MASKS, 32'h0000_FFFF);
		wr(REG_ADDR_U, 32'h0000_0008);
		for (op = 5'h01; op < 5'h10; op++)
		begin
			old = $urandom();
			s0 = (op == 5'h0E) ? old : $urandom();
			s1 = $urandom();
			nw = aop(op[3:0], old, s0, s1);
			wr(9'h108, old);
			wr(REG_SRC0_LO, s0);
			wr(REG_SRC1_LO, s1);
			wr(REG_COMMAND, {18'h0, 2'b10, op[3:0], 8'h05});
			rd(REG_RDATA0, (op == 5'h0F) ? nw : old);
			rd(9'h108, nw);
		end
		// return disabled leaves the previous result in place
		wr(REG_COMMAND, 32'h0000_0705);
		rd(REG_RDATA0, nw);
		rd(9'h108, nw + s0);
		wr(REG_SURF_CFG, 32'h0000_0043);
		wr(REG_LANE_MASKS, 32'hFFFE_FFFF);
		wr(REG_COMMAND, 32'h0000_2505);
		rd(9'h108, nw + s0);
		wr(REG_SURF_CFG, 32'h0000_0003);
		for (int c = 0; c < 4; c++)
		begin
			w[c] = $urandom();
			wr(9'h108 + 9'(4 * c), w[c]);
		end
		wr(REG_COMMAND, 32'h0000_0003);
		for (int c = 0; c < 4; c++)
			rd(REG_RDATA0 + 9'(4 * c), w[c]);
		wr(REG_SURF_LIMIT, 32'h0000_0008);
		wr(REG_WDATA0, ~w[0]);
		wr(REG_COMMAND, 32'h0000_0004);
		rd(9'h108, w[0]);
		wr(REG_COMMAND, 32'h0000_0003);
		for (int c = 0; c < 4; c++)
			rd(REG_RDATA0 + 9'(4 * c), 32'h0000_0000);
		rd(REG_STATUS, 32'hFFFF_0002);
		rd(9'h044, 32'h0000_0000);
		wr(REG_SURF_LIMIT, 32'h0000_0100);
		wr(REG_SRC0_LO, w[0]);
		wr(REG_SRC0_HI, w[1]);
		wr(REG_SRC1_HI, w[3]);
		wr(REG_COMMAND, 32'h0000_2005);
		rd(REG_RDATA0, w[0]);
		rd(REG_RDATA0 + 9'h004, w[1]);
		rd(9'h108, s1);
		rd(9'h10C, w[3]);
		// typed, eight-lane: only the high header half enables slot 0
		wr(REG_SURF_CFG, 32'h0000_0073);
		wr(REG_SURF_SIZE, 32'h0000_0010);
		wr(REG_LANE_MASKS, 32'h0100_00FF);
		wr(REG_WDATA0, 32'h0000_0123);
		wr(REG_COMMAND, 32'h0000_0011);
		rd(9'h120, 32'h0000_0000);
		wr(REG_COMMAND, 32'h0000_2011);
		rd(9'h120, 32'h0000_00FF);
		wr(REG_SURF_CFG, 32'h0000_0043);
		wr(REG_COMMAND, 32'h0000_3712);
		rd(REG_RDATA0, 32'h0000_00FF);
		rd(9'h120, 32'h0000_00FF + w[0]);
		wr(REG_COMMAND, 32'h0000_2010);
		rd(REG_RDATA0, 32'h0000_00FF + w[0]);
		repeat (2) @(posedge ref_clk);
		end_sim();
	end
endmodule
`default_nettype wire

// *** tb/thread_master.sv ***
`timescale 1ns/100ps
`default_nettype none
module thread_master
(
	// clock
	input  wire logic        i_ref_clk,
	// slave answer
	input  wire logic        i_waitrequest,
	// request
	output logic      [8:0]  o_address,
	output logic             o_read,
	output logic             o_write,
	output logic      [31:0] o_writedata,
	output logic      [3:0]  o_byteenable
);
	initial
	begin
		o_address = 9'h000;
		o_read = 1'b0;
		o_write = 1'b0;
		o_writedata = 32'h0000_0000;
		o_byteenable = 4'hF;
	end
	// request held until accepted; released lines show inverted data, never stale values
	task automatic access(input logic wr, input logic [8:0] a, input logic [31:0] d);
		@(posedge i_ref_clk);
		o_address <= a;
		o_read <= !wr;
		o_write <= wr;
		o_writedata <= d;
		@(posedge i_ref_clk);
		while (i_waitrequest)
			@(posedge i_ref_clk);
		o_read <= 1'b0;
		o_write <= 1'b0;
		o_address <= ~a;
		o_writedata <= ~d;
	endtask
endmodule
`default_nettype wire
